// ### common/rtu_pkg.sv
// Purpose: shared constants and types of the reader timer unit
// Assumes: registers sit in the low byte of 32-bit Avalon words
// Notes:   byte address of a register is four times its index
package rtu_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_MODE = 6'h2A; // timer_mode_control
   localparam logic [5:0] IDX_PRESC = 6'h2B; // timer_prescale_low
   localparam logic [5:0] IDX_RLD_HI = 6'h2C; // timer_reload_high
   localparam logic [5:0] IDX_RLD_LO = 6'h2D; // timer_reload_low
   localparam logic [5:0] IDX_CNT_HI = 6'h2E; // timer_count_high
   localparam logic [5:0] IDX_CNT_LO = 6'h2F; // timer_count_low
   localparam logic [5:0] IDX_CTRL = 6'h38; // timer control bits
   localparam logic [5:0] IDX_STAT = 6'h39; // sticky status
   localparam logic [5:0] IDX_MASK = 6'h3A; // interrupt mask

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam int CTRL_START = 0; // write 1: software start event
   localparam int CTRL_STOP = 1; // write 1: stop_immediately
   localparam int CTRL_EVEN = 2; // even_divisor_select
   localparam int CTRL_MULTI = 3; // multi_frame_receive
   localparam int STAT_EXPIRY = 0; // expiry_irq_flag
   localparam int STAT_RXSTOP = 1; // stopped after fifth bit
   localparam int STAT_RUN = 7; // counting_active, read only
   localparam logic [1:0] EVT_MASK_BITS = 2'h3;

   // ----------------------------------------------------------------
   // gating codes and protocol counts
   // ----------------------------------------------------------------
   localparam logic [1:0] GATE_NONE = 2'h0;
   localparam logic [1:0] GATE_IFACE = 2'h1;
   localparam logic [1:0] GATE_AUXILIARY_PIN_ONE = 2'h2;
   localparam logic [2:0] RX_STOP_BITS = 3'h5; // start bit + 4 data
   localparam logic [2:0] RX_ONE = 3'h1;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [12:0] DIV_ONE = 13'h0001;
   localparam logic [12:0] DIV_ZERO = 13'h0000;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic auto_start_on_tx_end; // bit 7
      logic [1:0] gate_source_select; // bits 6:5
      logic reload_on_expiry; // bit 4
      logic [3:0] prescale_upper_nibble; // bits 3:0
   } rtu_mode_t;

   typedef struct packed {
      logic even_divisor_select;
      logic multi_frame_receive;
   } rtu_opt_t;

   typedef enum logic {ST_IDLE, ST_RUN} rtu_state_t;
endpackage : rtu_pkg

// ### rtl/rtu_prescaler.sv
// Purpose: divides CLK into timer ticks, 2*p+1 or 2*p+2 cycles apart
// Assumes: run low clears the divider so a start is phase aligned
// Notes:   tick is a one-cycle pulse, or steady with divisor one, only while run is high
`timescale 1ns/1ps
module rtu_prescaler (
   // clock and control
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic run,
   // divisor setting
   input wire logic [11:0] prescale,
   input wire logic even,
   // tick out
   output logic tick
);
   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   logic [12:0] div_cnt; // cycles since last tick
   logic [12:0] terminal; // divisor minus one: 2*p or 2*p+1
   logic [12:0] next_div_cnt;

   assign terminal = {prescale, even};
   assign tick = run && (div_cnt == terminal);
   assign next_div_cnt = (!run || tick) ? rtu_pkg::DIV_ZERO
                                        : div_cnt + rtu_pkg::DIV_ONE;

   // divider register, frozen while ce is low
   always_ff @(posedge clk) begin
      if (reset) begin
         div_cnt <= rtu_pkg::DIV_ZERO;
      end else if (ce) begin
         div_cnt <= next_div_cnt;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // a stop or a new divisor in the next cycle excuses the tick
   a_tick_period: assert property (@(posedge clk) disable iff (reset)
      (ce && tick && terminal == rtu_pkg::DIV_ZERO)
      |=> (ce && run && terminal == rtu_pkg::DIV_ZERO) |-> tick)
      else $error("tick missing with divisor one");
endmodule : rtu_prescaler

// ### rtl/rtu_timer.sv
// Purpose: reader timer unit, down counter with prescaler and gating
// Assumes: TX_END and RX_BIT are one-cycle pulses synchronous to CLK
// Notes:   the tick is divided from CLK itself, the only clock here
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module rtu_timer (
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CE,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // protocol events
   input wire logic TX_END,
   input wire logic RX_BIT,
   // gate pins
   input wire logic IFACE_IN,
   input wire logic AUXILIARY_PIN_ONE_IN,
   // interrupt
   output logic IRQ
);
   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   rtu_pkg::rtu_mode_t mode; // timer_mode_control
   rtu_pkg::rtu_opt_t opt; // even divisor and multi-frame bits
   logic [7:0] prescale_lower_byte; // timer_prescale_low
   logic [7:0] reload_upper_byte; // timer_reload_high
   logic [7:0] reload_lower_byte; // timer_reload_low
   logic [1:0] stat; // sticky event flags
   logic [1:0] mask; // interrupt mask, same layout
   logic rd_valid; // read data ready this cycle

   // ----------------------------------------------------------------
   // timer state
   // ----------------------------------------------------------------
   rtu_pkg::rtu_state_t state; // idle or counting
   logic [15:0] count; // current count
   logic rx_watch; // armed by an auto start
   logic [2:0] rx_bits; // received bits since auto start

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic [5:0] idx; // word index
   logic wr_ok; // write taken this cycle
   logic wr_mode, wr_presc, wr_rld_hi, wr_rld_lo;
   logic wr_ctrl, wr_stat, wr_mask;
   logic [7:0] wdat; // low byte lane

   assign idx = AVS_ADDRESS[7:2];
   assign wdat = AVS_WRITEDATA[7:0];
   // only lane 0 carries data; other lanes are dropped
   assign wr_ok = CE && AVS_WRITE && AVS_BYTEENABLE[0];
   assign wr_mode = wr_ok && (idx == rtu_pkg::IDX_MODE);
   assign wr_presc = wr_ok && (idx == rtu_pkg::IDX_PRESC);
   assign wr_rld_hi = wr_ok && (idx == rtu_pkg::IDX_RLD_HI);
   assign wr_rld_lo = wr_ok && (idx == rtu_pkg::IDX_RLD_LO);
   assign wr_ctrl = wr_ok && (idx == rtu_pkg::IDX_CTRL);
   assign wr_stat = wr_ok && (idx == rtu_pkg::IDX_STAT);
   assign wr_mask = wr_ok && (idx == rtu_pkg::IDX_MASK);

   // writes finish at once, reads take one wait cycle
   assign AVS_WAITREQUEST = AVS_READ && !rd_valid;

   // ----------------------------------------------------------------
   // gating and control events
   // ----------------------------------------------------------------
   logic gate_ok; // selected gate permits counting
   logic running; // timer armed
   logic sw_start, sw_stop; // software strobes
   logic auto_start; // transmission end with auto-start
   logic start_evt; // any start event
   logic rx_stop; // fifth bit seen
   logic tick; // prescaled tick
   logic dec_en; // decrement this cycle
   logic expire; // count reaches zero
   logic [15:0] reload; // reload pair
   logic [11:0] prescale; // 12-bit prescaler value
   logic counting_active; // status view

   // code 11 has no function, so it holds the counter
   assign gate_ok =
      (mode.gate_source_select == rtu_pkg::GATE_NONE) ? 1'b1 :
      (mode.gate_source_select == rtu_pkg::GATE_IFACE) ? IFACE_IN :
      (mode.gate_source_select == rtu_pkg::GATE_AUXILIARY_PIN_ONE) ? AUXILIARY_PIN_ONE_IN :
      1'b0;
   assign running = (state == rtu_pkg::ST_RUN);
   assign sw_start = wr_ctrl && wdat[rtu_pkg::CTRL_START];
   assign sw_stop = wr_ctrl && wdat[rtu_pkg::CTRL_STOP];
   // protocol events only matter with auto-start set
   assign auto_start = CE && mode.auto_start_on_tx_end && TX_END;
   assign start_evt = sw_start || auto_start;
   // multi-frame receive leaves stopping to software and expiry
   assign rx_stop = CE && running && rx_watch && RX_BIT &&
      mode.auto_start_on_tx_end && !opt.multi_frame_receive &&
      (rx_bits == rtu_pkg::RX_STOP_BITS - rtu_pkg::RX_ONE);
   assign dec_en = CE && running && tick && gate_ok;
   assign expire = dec_en && (count <= rtu_pkg::CNT_ONE);
   assign reload = {reload_upper_byte, reload_lower_byte};
   assign prescale = {mode.prescale_upper_nibble,
                      prescale_lower_byte};
   // status reads the gate result, it never drives it
   assign counting_active = running && gate_ok;

   // ----------------------------------------------------------------
   // prescaler
   // ----------------------------------------------------------------
   rtu_prescaler u_presc (
      .clk(CLK),
      .reset(RESET),
      .ce(CE),
      .run(running && !start_evt),
      .prescale(prescale),
      .even(opt.even_divisor_select),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // next values of the timer
   // ----------------------------------------------------------------
   logic stop_now; // any stop cause
   logic next_run; // next armed state
   logic [15:0] next_count;
   logic restart; // reload at expiry

   assign restart = expire && mode.reload_on_expiry;
   // a stop beats a start arriving in the same cycle
   assign stop_now = sw_stop || rx_stop || (expire && !restart);
   assign next_run = stop_now ? 1'b0 : (start_evt ? 1'b1 : running);
   // reload bytes reach the counter only through a start or an expiry restart
   assign next_count = (start_evt && !stop_now) ? reload :
                       restart ? reload :
                       expire ? rtu_pkg::CNT_RESET :
                       dec_en ? count - rtu_pkg::CNT_ONE :
                       count;

   // run state: a stop beats a start, and a start while counting
   // only reloads, so just idle has to look at start events
   rtu_pkg::rtu_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         rtu_pkg::ST_IDLE: begin
            if (start_evt && !stop_now) next_state = rtu_pkg::ST_RUN;
         end
         rtu_pkg::ST_RUN: begin
            if (stop_now) next_state = rtu_pkg::ST_IDLE;
         end
      endcase
   end

   // state register, frozen while CE is low
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state <= rtu_pkg::ST_IDLE;
      end else if (CE) begin
         state <= next_state;
      end
   end

   // counter
   always_ff @(posedge CLK) begin
      if (RESET) begin
         count <= rtu_pkg::CNT_RESET;
      end else if (CE) begin
         count <= next_count;
      end
   end

   // received bit watch, armed only by an auto start
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rx_watch <= 1'b0;
         rx_bits <= '0;
      end else if (CE) begin
         if (auto_start && !stop_now) begin
            rx_watch <= 1'b1;
            rx_bits <= '0;
         end else if (!next_run) begin
            rx_watch <= 1'b0;
         end else if (rx_watch && RX_BIT) begin
            rx_bits <= rx_bits + rtu_pkg::RX_ONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RESET) begin
         mode <= rtu_pkg::REG_RESET;
         prescale_lower_byte <= rtu_pkg::REG_RESET;
      end else begin
         if (wr_mode) mode <= wdat;
         if (wr_presc) prescale_lower_byte <= wdat;
      end
   end

   // reload pair; the counter keeps running untouched
   always_ff @(posedge CLK) begin
      if (RESET) begin
         reload_upper_byte <= rtu_pkg::REG_RESET;
         reload_lower_byte <= rtu_pkg::REG_RESET;
      end else begin
         if (wr_rld_hi) reload_upper_byte <= wdat;
         if (wr_rld_lo) reload_lower_byte <= wdat;
      end
   end

   // options and mask
   always_ff @(posedge CLK) begin
      if (RESET) begin
         opt <= '0;
         mask <= '0;
      end else begin
         if (wr_ctrl) begin
            opt.even_divisor_select <= wdat[rtu_pkg::CTRL_EVEN];
            opt.multi_frame_receive <= wdat[rtu_pkg::CTRL_MULTI];
         end
         if (wr_mask) mask <= wdat[1:0] & rtu_pkg::EVT_MASK_BITS;
      end
   end

   // ----------------------------------------------------------------
   // sticky status and interrupt
   // ----------------------------------------------------------------
   logic [1:0] evt; // events this cycle
   logic [1:0] clr; // write-one-to-clear
   logic [1:0] next_stat;

   assign evt = {rx_stop, expire};
   assign clr = wr_stat ? wdat[1:0] : 2'h0;
   // a new event wins over a clear in the same cycle
   assign next_stat = (stat & ~clr) | evt;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         stat <= '0;
      end else if (CE) begin
         stat <= next_stat;
      end
   end

   assign IRQ = |(stat & mask);

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   logic [7:0] rd_byte; // selected register
   logic [7:0] stat_view;

   assign stat_view = {counting_active, 5'h00, stat};
   assign rd_byte =
      (idx == rtu_pkg::IDX_MODE) ? mode :
      (idx == rtu_pkg::IDX_PRESC) ? prescale_lower_byte :
      (idx == rtu_pkg::IDX_RLD_HI) ? reload_upper_byte :
      (idx == rtu_pkg::IDX_RLD_LO) ? reload_lower_byte :
      (idx == rtu_pkg::IDX_CNT_HI) ? count[15:8] :
      (idx == rtu_pkg::IDX_CNT_LO) ? count[7:0] :
      (idx == rtu_pkg::IDX_CTRL) ?
         {4'h0, opt.multi_frame_receive, opt.even_divisor_select,
          2'h0} :
      (idx == rtu_pkg::IDX_STAT) ? stat_view :
      (idx == rtu_pkg::IDX_MASK) ? {6'h00, mask} :
      8'h00; // unmapped reads as zero

   // read data registered during the single wait cycle
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rd_valid <= 1'b0;
         AVS_READDATA <= '0;
      end else begin
         rd_valid <= AVS_READ && !rd_valid;
         if (AVS_READ && !rd_valid) AVS_READDATA <= {24'h000000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   a_stop_write: assert property (sw_stop |=> !running)
      else $error("stop write did not halt timer");
   a_auto_start: assert property (
      auto_start && !stop_now |=> running && count == $past(reload))
      else $error("auto start did not load reload");
   a_proto_ignored: assert property (
      CE && !mode.auto_start_on_tx_end && !running && !sw_start
      |=> !running)
      else $error("timer started without auto start");
   // stop and flag land on the edge of the fifth bit itself
   a_rx_fifth: assert property (
      rx_stop |=> !running && stat[rtu_pkg::STAT_RXSTOP])
      else $error("fifth bit did not stop timer");
   a_multi_keeps: assert property (
      running && opt.multi_frame_receive && !sw_stop && !expire
      |=> running)
      else $error("timer stopped itself in multi frame");
   a_expiry_flag: assert property (
      expire && !mode.reload_on_expiry |=> !running
      && stat[rtu_pkg::STAT_EXPIRY] && count == rtu_pkg::CNT_RESET)
      else $error("expiry did not stop and flag");
   a_restart: assert property (
      restart && !sw_stop && !rx_stop |=> running
      && count == $past(reload))
      else $error("auto restart did not reload");
   a_gate_hold: assert property (
      CE && running && !gate_ok && !start_evt |=> count == $past(count))
      else $error("count moved while gated off");
   a_reload_safe: assert property (
      (wr_rld_hi || wr_rld_lo) && !start_evt && !dec_en
      |=> count == $past(count))
      else $error("reload write disturbed count");
   // status recomputed from the pins, so a broken gate mux shows up
   a_status_gate: assert property (
      stat_view[rtu_pkg::STAT_RUN] == (running &&
      ((mode.gate_source_select == rtu_pkg::GATE_NONE) ||
       (mode.gate_source_select == rtu_pkg::GATE_IFACE && IFACE_IN) ||
       (mode.gate_source_select == rtu_pkg::GATE_AUXILIARY_PIN_ONE && AUXILIARY_PIN_ONE_IN))))
      else $error("running status wrong");
   a_read_wait: assert property (
      AVS_READ && !rd_valid ##1 AVS_READ |-> !AVS_WAITREQUEST)
      else $error("read not answered in one wait");

   c_auto_run: cover property (auto_start ##[1:50] expire);
   c_rx_stop: cover property (rx_stop);
   c_restart: cover property (restart ##[1:50] restart);
   c_irq: cover property (IRQ);
endmodule : rtu_timer

// ### tb/rtu_timer_tb.sv
// Purpose: self-checking bench of the reader timer unit
// Assumes: one wait on reads, none on writes, tick derived from CLK
// Notes:   settings drawn from a fixed seed, corner cases hand-written
`timescale 1ns/1ps
module rtu_timer_tb;
   // ----------------------------------------------------------------
   // signals and counters
   // ----------------------------------------------------------------
   logic clk = 1'b0; // 100 ns period
   logic reset = 1'b1; // held for six cycles
   logic ce = 1'b1; // dropped once to check the freeze
   logic [7:0] addr = 8'h00; // byte address
   logic rd_req = 1'b0;
   logic wr_req = 1'b0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] ben = 4'hF; // lane 0 always written
   logic tx_end = 1'b0;
   logic rx_bit = 1'b0;
   logic iface_in = 1'b0;
   logic auxiliary_pin_one_in = 1'b0;
   logic [7:0] ctrl_opt = 8'h00; // even/multi bits kept on ctrl writes, except the start and stop writes of the enable test
   wire [31:0] rdata;
   wire waitreq;
   wire irq;
   int n_mismatch = 0;
   int cmp_count = 0;
   int seed = 32'hd0f8;

   rtu_timer rtu_timer_i (.CLK(clk), .RESET(reset), .CE(ce),
      .AVS_ADDRESS(addr), .AVS_READ(rd_req), .AVS_WRITE(wr_req),
      .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(ben),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .TX_END(tx_end), .RX_BIT(rx_bit), .IFACE_IN(iface_in),
      .AUXILIARY_PIN_ONE_IN(auxiliary_pin_one_in), .IRQ(irq));

   // free running clock
   initial begin
      forever #50 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // compare, bus and expectation helpers
   // ----------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_byte

   task automatic cmp_cyc(input int got, input int exp);
      cmp_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_cyc

   // the leading edge keeps a release and the next raise apart
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      wdata <= {24'h000000, d};
      wr_req <= 1'b1;
      do @(posedge clk); while (waitreq !== 1'b0);
      wr_req <= 1'b0;
   endtask : wr

   task automatic rd(input logic [5:0] idx, output logic [7:0] d);
      @(posedge clk);
      addr <= {idx, 2'b00};
      rd_req <= 1'b1;
      do @(posedge clk); while (waitreq !== 1'b0);
      d = rdata[7:0];
      rd_req <= 1'b0;
   endtask : rd

   task automatic rd_chk(input logic [5:0] idx, input logic [7:0] msk,
                         input logic [7:0] exp);
      logic [7:0] d;
      rd(idx, d);
      cmp_byte(d & msk, exp);
   endtask : rd_chk

   // one-cycle protocol pulse: 0 transmission end, 1 received bit
   task automatic pulse(input bit which);
      @(posedge clk);
      if (which) rx_bit <= 1'b1;
      else tx_end <= 1'b1;
      @(posedge clk);
      rx_bit <= 1'b0;
      tx_end <= 1'b0;
   endtask : pulse

   // cycles from the start edge until the irq level appears
   task automatic wait_irq(input int exp);
      int n;
      n = 0;
      while (n < 8000) begin
         @(negedge clk);
         if (irq === 1'b1) break;
         n++;
      end
      cmp_cyc(n, exp);
   endtask : wait_irq

   function automatic int divisor(input logic [11:0] p, input logic ev);
      return 2 * p + 1 + ev;
   endfunction : divisor

   task automatic stop_test;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // watchdog: longest run is well below this span
   // ----------------------------------------------------------------
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      stop_test;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [5:0] regs [9];
      logic [7:0] v, a, b;
      logic [11:0] p;
      logic ev;
      int r;
      regs = '{rtu_pkg::IDX_MODE, rtu_pkg::IDX_PRESC, rtu_pkg::IDX_RLD_HI,
               rtu_pkg::IDX_RLD_LO, rtu_pkg::IDX_CNT_HI, rtu_pkg::IDX_CNT_LO,
               rtu_pkg::IDX_STAT, rtu_pkg::IDX_MASK, 6'h30};
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      // reset values, unmapped place included
      foreach (regs[i]) rd_chk(regs[i], 8'hFF, rtu_pkg::REG_RESET);
      wr(6'h30, 8'hFF);
      rd_chk(6'h30, 8'hFF, 8'h00);
      $display("test reset done");
      // read back of random settings
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         wr(rtu_pkg::IDX_PRESC, v);
         wr(rtu_pkg::IDX_RLD_HI, ~v);
         wr(rtu_pkg::IDX_MODE, v & 8'h7F);
         rd_chk(rtu_pkg::IDX_PRESC, 8'hFF, v);
         rd_chk(rtu_pkg::IDX_RLD_HI, 8'hFF, ~v);
         rd_chk(rtu_pkg::IDX_MODE, 8'hFF, v & 8'h7F);
      end
      $display("test registers done");
      // divisor and one-shot expiry; first pass is the shortest corner
      wr(rtu_pkg::IDX_MASK, 8'h03);
      wr(rtu_pkg::IDX_RLD_HI, 8'h00);
      for (int i = 0; i < 5; i++) begin
         p = (i == 0) ? 12'h000 : 12'($random(seed) & 12'h10F);
         ev = (i == 0) ? 1'b0 : 1'($random(seed));
         r = (i == 0) ? 1 : 2 + ($random(seed) & 3);
         ctrl_opt = ev ? 8'h04 : 8'h00;
         wr(rtu_pkg::IDX_MODE, {4'h0, p[11:8]});
         wr(rtu_pkg::IDX_PRESC, p[7:0]);
         wr(rtu_pkg::IDX_RLD_LO, r[7:0]);
         wr(rtu_pkg::IDX_CTRL, ctrl_opt | 8'h01);
         wait_irq(r * divisor(p, ev));
         rd_chk(rtu_pkg::IDX_CNT_LO, 8'hFF, 8'h00);
         rd_chk(rtu_pkg::IDX_STAT, 8'hFF, 8'h01);
         wr(rtu_pkg::IDX_STAT, 8'h01);
         @(negedge clk);
         cmp_byte({7'h00, irq}, 8'h00);
      end
      $display("test divisor done");
      // auto restart keeps running; mask hides the flag; stop halts
      ctrl_opt = 8'h00;
      wr(rtu_pkg::IDX_MODE, 8'h10);
      wr(rtu_pkg::IDX_PRESC, 8'h00);
      wr(rtu_pkg::IDX_RLD_LO, 8'h04);
      wr(rtu_pkg::IDX_CTRL, 8'h01);
      wait_irq(4);
      rd_chk(rtu_pkg::IDX_STAT, 8'h80, 8'h80);
      wr(rtu_pkg::IDX_MASK, 8'h00);
      @(negedge clk);
      cmp_byte({7'h00, irq}, 8'h00);
      wr(rtu_pkg::IDX_CTRL, 8'h02);
      rd(rtu_pkg::IDX_CNT_LO, a);
      rd(rtu_pkg::IDX_CNT_LO, b);
      cmp_byte(b, a);
      rd_chk(rtu_pkg::IDX_STAT, 8'h80, 8'h00);
      $display("test restart done");
      // reload change during a count waits for the next start
      wr(rtu_pkg::IDX_MODE, 8'h00);
      wr(rtu_pkg::IDX_RLD_HI, 8'h80);
      wr(rtu_pkg::IDX_RLD_LO, 8'h00);
      wr(rtu_pkg::IDX_CTRL, 8'h01);
      wr(rtu_pkg::IDX_RLD_HI, 8'h00);
      wr(rtu_pkg::IDX_RLD_LO, 8'h03);
      rd_chk(rtu_pkg::IDX_CNT_HI, 8'hFF, 8'h7F);
      wr(rtu_pkg::IDX_STAT, 8'h03);
      wr(rtu_pkg::IDX_MASK, 8'h01);
      wr(rtu_pkg::IDX_CTRL, 8'h01);
      wait_irq(3);
      wr(rtu_pkg::IDX_STAT, 8'h03);
      $display("test reload done");
      // protocol start and stop
      wr(rtu_pkg::IDX_RLD_HI, 8'h80);
      pulse(1'b0);
      rd_chk(rtu_pkg::IDX_STAT, 8'h80, 8'h00);
      wr(rtu_pkg::IDX_MODE, 8'h80);
      pulse(1'b0);
      rd_chk(rtu_pkg::IDX_STAT, 8'h80, 8'h80);
      repeat (4) pulse(1'b1);
      rd_chk(rtu_pkg::IDX_STAT, 8'h82, 8'h80);
      pulse(1'b1);
      rd_chk(rtu_pkg::IDX_STAT, 8'h82, 8'h02);
      wr(rtu_pkg::IDX_STAT, 8'h02);
      ctrl_opt = 8'h08;
      wr(rtu_pkg::IDX_CTRL, ctrl_opt);
      pulse(1'b0);
      repeat (6) pulse(1'b1);
      rd_chk(rtu_pkg::IDX_STAT, 8'h82, 8'h80);
      wr(rtu_pkg::IDX_CTRL, ctrl_opt | 8'h02);
      rd_chk(rtu_pkg::IDX_STAT, 8'h82, 8'h00);
      $display("test protocol done");
      // enable low freezes a running count; reads still answer
      wr(rtu_pkg::IDX_MODE, 8'h00);
      wr(rtu_pkg::IDX_CTRL, 8'h01);
      ce <= 1'b0;
      rd(rtu_pkg::IDX_CNT_LO, a);
      rd(rtu_pkg::IDX_CNT_LO, b);
      cmp_byte(b, a);
      ce <= 1'b1;
      wr(rtu_pkg::IDX_CTRL, 8'h02);
      $display("test enable done");
      // every gate code against both pin levels, pins driven apart
      ctrl_opt = 8'h00;
      for (int g = 0; g < 4; g++) begin
         for (int l = 0; l < 2; l++) begin
            @(posedge clk);
            iface_in <= l[0];
            auxiliary_pin_one_in <= ~l[0];
            wr(rtu_pkg::IDX_MODE, {1'b0, g[1:0], 5'h00});
            wr(rtu_pkg::IDX_CTRL, 8'h01);
            rd(rtu_pkg::IDX_CNT_LO, a);
            rd(rtu_pkg::IDX_CNT_LO, b);
            v = 8'(g == 0 || (g == 1 && l == 1) || (g == 2 && l == 0));
            cmp_byte({7'h00, a !== b}, v);
            rd_chk(rtu_pkg::IDX_STAT, 8'h80, {v[0], 7'h00});
            wr(rtu_pkg::IDX_CTRL, 8'h02);
         end
      end
      $display("test gating done");
      stop_test;
   end
endmodule : rtu_timer_tb
